// File: level_guard_defs.vh
// shared constants for the level guard and sleep/wake sequencer
`ifndef LEVEL_GUARD_DEFS_VH
`define LEVEL_GUARD_DEFS_VH
`define ACT_NONE 2'h0
`define ACT_ALARM 2'h1
`define ACT_FAULT 2'h2
`define ACT_BOTH 2'h3
`define LOW_THRESHOLD_RST 16'h0000
`define HIGH_THRESHOLD_RST 16'h0000
`define LOW_TIME_RST 14'h0000
`define HIGH_TIME_RST 14'h0000
`define WAKE_DEVIATION_RST 16'h01f4
`define WAKE_TIME_RST 14'h0032
`define SLEEP_SPEED_RST 16'h0064
`define SLEEP_SPEED_MAX 16'hea60
`define SLEEP_TIME_RST 14'h0064
`define TIME_MAX 14'h270f
`define TICK_PERIOD_NS 100000000
`define CLK_PERIOD_NS 25
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define EVT_LOW_ALARM 16'h0001
`define EVT_HIGH_ALARM 16'h0002
`define EVT_NONE 16'h0000
`define REG_CTRL 12'h000
`define REG_LOW_THR 12'h004
`define REG_LOW_TIME 12'h008
`define REG_HIGH_THR 12'h00c
`define REG_HIGH_TIME 12'h010
`define REG_WAKE_DEV 12'h014
`define REG_WAKE_TIME 12'h018
`define REG_SLEEP_SPD 12'h01c
`define REG_SLEEP_TIME 12'h020
`define REG_MIN_SPD 12'h024
`define REG_STATUS 12'h028
`define REG_IRQ_STAT 12'h02c
`define REG_IRQ_MASK 12'h030
`define MIN_SPEED_RST 16'h0000
`endif

// File: tick_divider.v
// divider producing the 0.1 s tick enable
`timescale 1ns/1ps
`default_nettype none
`include "level_guard_defs.vh"
module tick_divider #(
  parameter [31:0] TICK_CYCLES = `TICK_CYCLES
) (
  input wire i_core_clk,
  input wire i_rst_n,
  output reg o_tick
);
  reg [31:0] count;
  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      count <= 32'h0;
      o_tick <= 1'b0;
    end
    else if (count >= TICK_CYCLES - 32'h1)
    begin
      count <= 32'h0;
      o_tick <= 1'b1;
    end
    else
    begin
      count <= count + 32'h1;
      o_tick <= 1'b0;
    end
  end
endmodule // tick_divider
`default_nettype wire

// File: persist_timer.v
// persistence timer counting ticks while a condition holds
`timescale 1ns/1ps
`default_nettype none
module persist_timer (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_tick,
  input wire i_cond,
  input wire [13:0] i_limit,
  output wire o_done
);
  reg [13:0] count;
  // zero limit means done as soon as the condition holds
  assign o_done = i_cond && (count >= i_limit);
  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      count <= 14'h0;
    else if (!i_cond)
      count <= 14'h0;
    else if (i_tick && count < i_limit)
      count <= count + 14'h1;
  end
endmodule // persist_timer
`default_nettype wire

// File: pid_level_guard_sleep_wake.v
// level protection and sleep/wake sequencer with apb registers
// How it works
// - low action code: none, alarm, fault, or both when below low threshold
// - signed 16-bit low threshold, default zero, strict less-than compare
// - low fault needs low condition persisting for programmed time
// - high action uses same code, applies when strictly above high threshold
// - signed 16-bit high threshold, default zero
// - high fault needs high condition persisting for programmed time
// - low and high alarms report distinct event codes
// - sleep enable bit, default off
// - sequencer acts only when controller enabled and automatic
// - wake threshold is setpoint minus/plus deviation by direction
// - wake must persist for wake time; lapse restarts count
// - run active at power-up with wake true starts motor at once
// - run active without completed wake stays asleep, motor stopped
// - on wake ramp to minimum speed before handing to controller
// - sleep countdown while speed below threshold, aborts otherwise
// - after sleep time issue stop, sleep once speed reaches zero
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "level_guard_defs.vh"
module pid_level_guard_sleep_wake #(
  parameter [31:0] TICK_CYCLES = `TICK_CYCLES
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire [15:0] i_process_variable_value,
  input wire [15:0] i_setpoint,
  input wire [15:0] i_motor_speed,
  input wire i_run_stop_input,
  input wire i_pid_enabled,
  input wire i_pid_automatic,
  input wire i_pid_reverse,
  output reg o_low_alarm,
  output reg o_high_alarm,
  output reg o_low_fault,
  output reg o_high_fault,
  output reg [15:0] o_alarm_event_code,
  output reg o_motor_run,
  output reg o_min_speed_ramp,
  output reg o_pid_speed_control,
  output reg o_asleep,
  output reg o_irq
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_ASLEEP = 5'h02;
  localparam [4:0] ST_RAMP = 5'h04;
  localparam [4:0] ST_RUN = 5'h08;
  localparam [4:0] ST_STOPPING = 5'h10;

  // pins from outside the clock domain, two flops each
  reg [15:0] pv_s1, pv_s2, sp_s1, sp_s2, spd_s1, spd_s2;
  reg [4:0] st_s1, st_s2;
  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      pv_s1 <= 16'h0;
      pv_s2 <= 16'h0;
      sp_s1 <= 16'h0;
      sp_s2 <= 16'h0;
      spd_s1 <= 16'h0;
      spd_s2 <= 16'h0;
      st_s1 <= 5'h0;
      st_s2 <= 5'h0;
    end
    else
    begin
      pv_s1 <= i_process_variable_value;
      pv_s2 <= pv_s1;
      sp_s1 <= i_setpoint;
      sp_s2 <= sp_s1;
      spd_s1 <= i_motor_speed;
      spd_s2 <= spd_s1;
      st_s1 <= {i_run_stop_input, i_pid_enabled, i_pid_automatic, i_pid_reverse, 1'b0};
      st_s2 <= st_s1;
    end
  end
  wire run_cmd = st_s2[4];
  wire pid_en = st_s2[3];
  wire pid_auto = st_s2[2];
  wire pid_rev = st_s2[1];

  // configuration registers
  reg [1:0] low_level_action_cfg, high_level_action_cfg;
  reg [15:0] low_level_threshold, high_level_threshold;
  reg [13:0] low_level_fault_time, high_level_fault_time;
  reg sleep_enable_cfg;
  reg [15:0] wake_deviation, sleep_speed_threshold, minimum_motor_speed;
  reg [13:0] wake_persist_time, sleep_persist_time;
  reg [1:0] irq_stat, irq_mask;
  reg [4:0] state;
  reg powerup_window;
  reg [1:0] settle;

  function [13:0] clamp_time;
    input [31:0] v;
    begin
      clamp_time = (v[13:0] > `TIME_MAX || v[31:14] != 18'h0) ? `TIME_MAX : v[13:0];
    end
  endfunction

  function has_alarm;
    input [1:0] act;
    begin
      has_alarm = (act == `ACT_ALARM) || (act == `ACT_BOTH);
    end
  endfunction

  function has_fault;
    input [1:0] act;
    begin
      has_fault = (act == `ACT_FAULT) || (act == `ACT_BOTH);
    end
  endfunction

  wire tick;
  tick_divider #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .o_tick(tick)
  );

  wire low_cond = $signed(pv_s2) < $signed(low_level_threshold);
  wire high_cond = $signed(pv_s2) > $signed(high_level_threshold);
  // wake threshold by direction, widened against overflow
  wire signed [16:0] wake_thr = pid_rev ?
    ($signed({sp_s2[15], sp_s2}) + $signed({wake_deviation[15], wake_deviation})) :
    ($signed({sp_s2[15], sp_s2}) - $signed({wake_deviation[15], wake_deviation}));
  wire signed [16:0] pv_wide = $signed({pv_s2[15], pv_s2});
  wire wake_cond = pid_rev ? (pv_wide > wake_thr) : (pv_wide < wake_thr);
  wire slow_cond = spd_s2 < sleep_speed_threshold;
  // sequencer active only in enabled automatic mode
  wire seq_active = sleep_enable_cfg && pid_en && pid_auto;

  wire low_done, high_done, wake_done, sleep_done;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_timer
      wire cond_w = (g == 0) ? low_cond : (g == 1) ? high_cond :
                    (g == 2) ? (wake_cond && seq_active) : (slow_cond && seq_active);
      wire [13:0] lim_w = (g == 0) ? low_level_fault_time : (g == 1) ? high_level_fault_time :
                          (g == 2) ? wake_persist_time : sleep_persist_time;
      wire done_w;
      persist_timer u_timer (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_tick(tick),
        .i_cond(cond_w),
        .i_limit(lim_w),
        .o_done(done_w)
      );
    end
  endgenerate
  assign low_done = g_timer[0].done_w;
  assign high_done = g_timer[1].done_w;
  assign wake_done = g_timer[2].done_w;
  assign sleep_done = g_timer[3].done_w;

  // level protection outputs
  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      o_low_alarm <= 1'b0;
      o_high_alarm <= 1'b0;
      o_low_fault <= 1'b0;
      o_high_fault <= 1'b0;
      o_alarm_event_code <= `EVT_NONE;
    end
    else
    begin
      o_low_alarm <= low_cond && has_alarm(low_level_action_cfg);
      o_high_alarm <= high_cond && has_alarm(high_level_action_cfg);
      if (low_done && has_fault(low_level_action_cfg))
        o_low_fault <= 1'b1;
      if (high_done && has_fault(high_level_action_cfg))
        o_high_fault <= 1'b1;
      if (low_cond && has_alarm(low_level_action_cfg))
        o_alarm_event_code <= `EVT_LOW_ALARM;
      else if (high_cond && has_alarm(high_level_action_cfg))
        o_alarm_event_code <= `EVT_HIGH_ALARM;
      else
        o_alarm_event_code <= `EVT_NONE;
    end
  end

  // sleep/wake sequencer
  reg [4:0] next_state;
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (run_cmd)
          next_state = seq_active ? ST_ASLEEP : ST_RUN;
      ST_ASLEEP:
        if (!run_cmd)
          next_state = ST_IDLE;
        else if (!seq_active || wake_done || (powerup_window && wake_cond))
          next_state = ST_RAMP;
      ST_RAMP:
        if (!run_cmd)
          next_state = ST_IDLE;
        else if (spd_s2 >= minimum_motor_speed)
          next_state = ST_RUN;
      ST_RUN:
        if (!run_cmd)
          next_state = ST_IDLE;
        else if (seq_active && sleep_done)
          next_state = ST_STOPPING;
      ST_STOPPING:
        if (!run_cmd)
          next_state = ST_IDLE;
        else if (spd_s2 == 16'h0)
          next_state = ST_ASLEEP;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      state <= ST_IDLE;
      powerup_window <= 1'b1;
      settle <= 2'h0;
      o_motor_run <= 1'b0;
      o_min_speed_ramp <= 1'b0;
      o_pid_speed_control <= 1'b0;
      o_asleep <= 1'b0;
    end
    else
    begin
      state <= next_state;
      settle <= {settle[0], 1'b1};
      // sync pipes read zero just after reset, so wait for them before closing
      if (state != ST_IDLE || (settle[1] && !run_cmd))
        powerup_window <= 1'b0;
      o_motor_run <= (next_state == ST_RAMP) || (next_state == ST_RUN);
      o_min_speed_ramp <= (next_state == ST_RAMP);
      o_pid_speed_control <= (next_state == ST_RUN);
      o_asleep <= (next_state == ST_ASLEEP);
    end
  end

  // apb slave, zero wait states
  wire apb_acc = i_psel && i_penable;
  wire apb_wr = apb_acc && i_pwrite;
  wire apb_rd = apb_acc && !i_pwrite;
  wire [1:0] irq_evt = {high_cond && has_alarm(high_level_action_cfg),
                        low_cond && has_alarm(low_level_action_cfg)};
  reg [31:0] rd_mux;
  reg rd_ok;
  always @*
  begin
    rd_ok = 1'b1;
    case (i_paddr)
      `REG_CTRL: rd_mux = {27'h0, sleep_enable_cfg, high_level_action_cfg, low_level_action_cfg};
      `REG_LOW_THR: rd_mux = {16'h0, low_level_threshold};
      `REG_LOW_TIME: rd_mux = {18'h0, low_level_fault_time};
      `REG_HIGH_THR: rd_mux = {16'h0, high_level_threshold};
      `REG_HIGH_TIME: rd_mux = {18'h0, high_level_fault_time};
      `REG_WAKE_DEV: rd_mux = {16'h0, wake_deviation};
      `REG_WAKE_TIME: rd_mux = {18'h0, wake_persist_time};
      `REG_SLEEP_SPD: rd_mux = {16'h0, sleep_speed_threshold};
      `REG_SLEEP_TIME: rd_mux = {18'h0, sleep_persist_time};
      `REG_MIN_SPD: rd_mux = {16'h0, minimum_motor_speed};
      `REG_STATUS: rd_mux = {23'h0, state, o_high_fault, o_low_fault, o_high_alarm, o_low_alarm};
      `REG_IRQ_STAT: rd_mux = {30'h0, irq_stat};
      `REG_IRQ_MASK: rd_mux = {30'h0, irq_mask};
      default:
      begin
        rd_mux = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      low_level_action_cfg <= `ACT_NONE;
      high_level_action_cfg <= `ACT_NONE;
      sleep_enable_cfg <= 1'b0;
      low_level_threshold <= `LOW_THRESHOLD_RST;
      high_level_threshold <= `HIGH_THRESHOLD_RST;
      low_level_fault_time <= `LOW_TIME_RST;
      high_level_fault_time <= `HIGH_TIME_RST;
      wake_deviation <= `WAKE_DEVIATION_RST;
      wake_persist_time <= `WAKE_TIME_RST;
      sleep_speed_threshold <= `SLEEP_SPEED_RST;
      sleep_persist_time <= `SLEEP_TIME_RST;
      minimum_motor_speed <= `MIN_SPEED_RST;
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
      o_prdata <= 32'h0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_irq <= 1'b0;
    end
    else
    begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !rd_ok;
      o_prdata <= (i_psel && !i_penable && !i_pwrite) ? rd_mux : 32'h0;
      if (apb_wr && rd_ok)
      begin
        case (i_paddr)
          `REG_CTRL:
          begin
            low_level_action_cfg <= i_pwdata[1:0];
            high_level_action_cfg <= i_pwdata[3:2];
            sleep_enable_cfg <= i_pwdata[4];
          end
          `REG_LOW_THR: low_level_threshold <= i_pwdata[15:0];
          `REG_LOW_TIME: low_level_fault_time <= clamp_time(i_pwdata);
          `REG_HIGH_THR: high_level_threshold <= i_pwdata[15:0];
          `REG_HIGH_TIME: high_level_fault_time <= clamp_time(i_pwdata);
          `REG_WAKE_DEV: wake_deviation <= i_pwdata[15:0];
          `REG_WAKE_TIME: wake_persist_time <= clamp_time(i_pwdata);
          `REG_SLEEP_SPD: sleep_speed_threshold <= (i_pwdata[15:0] > `SLEEP_SPEED_MAX) ?
            `SLEEP_SPEED_MAX : i_pwdata[15:0];
          `REG_SLEEP_TIME: sleep_persist_time <= clamp_time(i_pwdata);
          `REG_MIN_SPD: minimum_motor_speed <= i_pwdata[15:0];
          `REG_IRQ_MASK: irq_mask <= i_pwdata[1:0];
          default: irq_mask <= irq_mask;
        endcase
      end
      // set wins over read-clear
      if (apb_rd && i_paddr == `REG_IRQ_STAT)
        irq_stat <= irq_evt;
      else
        irq_stat <= irq_stat | irq_evt;
      o_irq <= |(irq_stat & irq_mask);
    end
  end
endmodule // pid_level_guard_sleep_wake
`default_nettype wire

// File: guard_checks_asserts.sv
// port assertions for the level guard and sleep/wake sequencer
`timescale 1ns/1ps
`default_nettype none
module guard_checks (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_low_alarm,
  input wire logic o_high_alarm,
  input wire logic o_low_fault,
  input wire logic o_high_fault,
  input wire logic [15:0] o_alarm_event_code,
  input wire logic o_motor_run,
  input wire logic o_min_speed_ramp,
  input wire logic o_pid_speed_control,
  input wire logic o_asleep
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  low_fault_hold_a: assert property (o_low_fault |=> o_low_fault)
    else $error("low fault dropped");
  high_fault_hold_a: assert property (o_high_fault |=> o_high_fault)
    else $error("high fault dropped");
  apb_answer_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready too long");
  slverr_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("slverr without ready");
  low_code_a: assert property (o_low_alarm |-> o_alarm_event_code == 16'h0001)
    else $error("low event code");
  high_code_a: assert property (o_high_alarm && !o_low_alarm |-> o_alarm_event_code == 16'h0002)
    else $error("high event code");
  code_source_a: assert property (o_alarm_event_code == 16'h0001 |-> o_low_alarm)
    else $error("code without alarm");
  asleep_stopped_a: assert property (o_asleep |-> !o_motor_run)
    else $error("motor runs asleep");
  ramp_first_a: assert property (o_min_speed_ramp |-> !o_pid_speed_control)
    else $error("pid during ramp");
endmodule // guard_checks
bind pid_level_guard_sleep_wake guard_checks i_guard_checks (.i_core_clk, .i_rst_n, .i_psel,
  .i_penable, .o_pready, .o_pslverr, .o_low_alarm, .o_high_alarm, .o_low_fault, .o_high_fault,
  .o_alarm_event_code, .o_motor_run, .o_min_speed_ramp, .o_pid_speed_control, .o_asleep);
`default_nettype wire

// File: drive_speed_model.sv
// drive speed loop: follows demand while running, slows to zero when stopped
`timescale 1ns/1ps
`default_nettype none
module drive_speed_model #(
  parameter int STEP = 16
) (
  input wire logic i_core_clk,
  input wire logic i_run,
  input wire logic [15:0] i_demand,
  output logic [15:0] o_speed
);
  logic [15:0] target;
  assign target = i_run ? i_demand : 16'h0000;
  initial o_speed = 16'h0000;
  // finite slope, so the stopping state is seen before zero speed
  always @(posedge i_core_clk)
  begin
    if (o_speed + STEP <= target)
      o_speed <= o_speed + 16'(STEP);
    else if (o_speed >= target + STEP)
      o_speed <= o_speed - 16'(STEP);
    else
      o_speed <= target;
  end
endmodule // drive_speed_model
`default_nettype wire

// File: tb_pid_level_guard_sleep_wake.sv
// testbench for the level guard and sleep/wake sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_pid_level_guard_sleep_wake;
  logic i_core_clk, i_rst_n, i_psel, i_penable, i_pwrite, i_run_stop_input;
  logic i_pid_enabled, i_pid_automatic, i_pid_reverse;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, q;
  logic [15:0] i_process_variable_value, i_setpoint, i_motor_speed, demand, o_alarm_event_code;
  logic o_pready, o_pslverr, o_low_alarm, o_high_alarm, o_low_fault, o_high_fault, e;
  logic o_motor_run, o_min_speed_ramp, o_pid_speed_control, o_asleep, o_irq;
  int errors, checks_done, cycles, n;
  // short tick keeps the persistence times to tens of cycles
  pid_level_guard_sleep_wake #(.TICK_CYCLES(32'd10)) i_pid_level_guard_sleep_wake (.i_core_clk,
    .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
    .o_pslverr, .i_process_variable_value, .i_setpoint, .i_motor_speed, .i_run_stop_input,
    .i_pid_enabled, .i_pid_automatic, .i_pid_reverse, .o_low_alarm, .o_high_alarm,
    .o_low_fault, .o_high_fault, .o_alarm_event_code, .o_motor_run, .o_min_speed_ramp,
    .o_pid_speed_control, .o_asleep, .o_irq);
  drive_speed_model i_drive_speed_model (.i_core_clk, .i_run(o_motor_run), .i_demand(demand),
    .o_speed(i_motor_speed));
  initial
  begin
    i_core_clk = 0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge i_core_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1;
    do @(posedge i_core_clk); while (o_pready !== 1'b1);
    q = o_prdata;
    e = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic do_reset;
    i_rst_n <= 0;
    cyc(3);
    i_rst_n <= 1;
  endtask
  task automatic t_defaults;
    logic [11:0] ra [11] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014,
      12'h018, 12'h01c, 12'h020, 12'h024, 12'h040};
    logic [31:0] rv [11] = '{0, 0, 0, 0, 0, 32'h1f4, 32'h32, 32'h64, 32'h64, 0, 0};
    for (int i = 0; i < 11; i++)
    begin
      apb(1'b0, ra[i], 32'h0);
      chk(q, rv[i]);
      chk(e, i == 10);
    end
  endtask
  task automatic t_low;
    wr(12'h004, 32'h64);
    wr(12'h008, 32'h2);
    i_process_variable_value <= 16'h0064;
    wr(12'h000, 32'h3);
    cyc(8);
    chk(o_low_alarm, 0);
    i_process_variable_value <= 16'h0032;
    for (int c = 0; c < 2; c++)
    begin
      wr(12'h000, c);
      cyc(8);
      chk(o_low_alarm, c);
      chk(o_alarm_event_code, c);
    end
    i_process_variable_value <= 16'h0064;
    wr(12'h000, 32'h2);
    cyc(8);
    i_process_variable_value <= 16'h0032;
    cyc(8);
    chk(o_low_fault, 0);
    cyc(40);
    chk({o_low_fault, o_low_alarm}, 2'b10);
    i_process_variable_value <= 16'h0064;
    cyc(8);
    chk(o_low_fault, 1);
  endtask
  task automatic t_high;
    do_reset();
    chk(o_low_fault, 0);
    wr(12'h00c, 32'hff9c);
    i_process_variable_value <= 16'hff9c;
    wr(12'h000, 32'h4);
    cyc(8);
    chk(o_high_alarm, 0);
    i_process_variable_value <= 16'hffce;
    cyc(8);
    chk(o_high_alarm, 1);
    chk(o_alarm_event_code, 16'h0002);
    wr(12'h030, 32'h2);
    cyc(3);
    chk(o_irq, 1);
    apb(1'b0, 12'h02c, 32'h0);
    chk(q[1], 1);
    wr(12'h030, 32'h0);
    cyc(3);
    chk(o_irq, 0);
    wr(12'h000, 32'h8);
    cyc(8);
    chk({o_high_fault, o_high_alarm}, 2'b10);
  endtask
  task automatic t_powerup;
    i_run_stop_input <= 1;
    i_process_variable_value <= 16'd400;
    do_reset();
    cyc(6);
    chk({o_motor_run, o_asleep}, 2'b10);
    i_pid_automatic <= 0;
    demand <= 16'd50;
    wr(12'h000, 32'h10);
    wr(12'h020, 32'h1);
    cyc(60);
    chk(o_motor_run, 1);
    i_pid_automatic <= 1;
    demand <= 16'd400;
  endtask
  task automatic t_sleep;
    i_run_stop_input <= 0;
    i_process_variable_value <= 16'd800;
    do_reset();
    wr(12'h000, 32'h10);
    wr(12'h018, 32'h5);
    wr(12'h020, 32'h3);
    wr(12'h024, 32'd200);
    i_run_stop_input <= 1;
    cyc(10);
    chk({o_asleep, o_motor_run}, 2'b10);
    i_process_variable_value <= 16'd400;
    cyc(30);
    i_process_variable_value <= 16'd800;
    cyc(5);
    i_process_variable_value <= 16'd400;
    n = 0;
    while (o_motor_run !== 1'b1 && n < 200)
    begin
      @(posedge i_core_clk);
      n++;
    end
    chk(n >= 45 && n < 75, 1);
    chk({o_min_speed_ramp, o_pid_speed_control}, 2'b10);
    cyc(40);
    chk({o_min_speed_ramp, o_pid_speed_control}, 2'b01);
    i_process_variable_value <= 16'd800;
    demand <= 16'd50;
    n = 0;
    while (o_motor_run !== 1'b0 && n < 200)
    begin
      @(posedge i_core_clk);
      n++;
    end
    chk(n > 30 && n < 200, 1);
    chk(o_asleep, 0);
    cyc(15);
    chk(o_asleep, 1);
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge i_core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      report_and_stop();
    end
  end
  initial
  begin
    {i_rst_n, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = 0;
    {i_run_stop_input, i_pid_reverse} = 0;
    {i_pid_enabled, i_pid_automatic} = 2'b11;
    i_process_variable_value = 0;
    i_setpoint = 16'd1000;
    demand = 16'd400;
    cyc(3);
    i_rst_n <= 1;
    t_defaults();
    t_low();
    t_high();
    t_powerup();
    t_sleep();
    report_and_stop();
  end
endmodule // tb_pid_level_guard_sleep_wake
`default_nettype wire
